// file: design/dpm_top.v
`timescale 1ns/100ps
`include "dpm_map.vh"
module dpm_top #(
  parameter CLK_DIV = `DPM_CLK_DIV
) (
  // clock and reset
  input  wire       core_clk_in,
  input  wire       arst_n_in,
  // chip control
  input  wire       chip_init_n_in,
  input  wire       power_down_n_in,
  // port a
  input  wire [7:0] port_a_muxbus_in,
  output reg  [7:0] port_a_muxbus_out,
  output reg        port_a_muxbus_oe_out,
  input  wire       port_a_addr_hi_in,
  input  wire       port_a_addr_latch_in,
  input  wire       port_a_read_strobe_n_in,
  input  wire       port_a_store_strobe_n_in,
  input  wire       port_a_select_n_in,
  input  wire       port_a_select_in,
  // port b
  input  wire [7:0] port_b_muxbus_in,
  output reg  [7:0] port_b_muxbus_out,
  output reg        port_b_muxbus_oe_out,
  input  wire       port_b_addr_hi_in,
  input  wire       port_b_addr_latch_in,
  input  wire       port_b_read_strobe_n_in,
  input  wire       port_b_store_strobe_n_in,
  input  wire       port_b_select_n_in,
  input  wire       port_b_select_in,
  // clock, watchdog, timer and interrupt pins (open drain: oe high pulls low)
  output reg        clock_out,
  output reg        osc_alive_oe_out,
  output reg        timer_a_out_oe_out,
  output reg        timer_b_out_oe_out,
  output reg        timer_c_out_oe_out,
  output reg        irq_out_a_oe_out,
  output reg        irq_out_b_oe_out,
  output reg        irq_out_c_oe_out
);
  // ----------------------------------------
  // input synchronisers: 3 flops, change counts when 2nd and 3rd agree
  // ----------------------------------------
  localparam NS = 24;
  wire [NS-1:0] raw_w = {chip_init_n_in, power_down_n_in,
                         port_a_addr_hi_in, port_a_addr_latch_in, port_a_read_strobe_n_in,
                         port_a_store_strobe_n_in, port_a_select_n_in, port_a_select_in,
                         port_b_addr_hi_in, port_b_addr_latch_in, port_b_read_strobe_n_in,
                         port_b_store_strobe_n_in, port_b_select_n_in, port_b_select_in,
                         port_a_muxbus_in[7:3], port_b_muxbus_in[7:3]};
  reg [NS-1:0] s1_r, s2_r, s3_r, flt_r;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // idle levels, so no false latch edge or select shows up after reset
      s1_r  <= `DPM_SYNC_RST;
      s2_r  <= `DPM_SYNC_RST;
      s3_r  <= `DPM_SYNC_RST;
      flt_r <= `DPM_SYNC_RST;
    end else begin
      s1_r  <= raw_w;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
    end
  end
  // low bits of the buses go through the same three stages separately
  reg [5:0] d1_r, d2_r, d3_r, dflt_r;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      d1_r <= 6'h00; d2_r <= 6'h00; d3_r <= 6'h00; dflt_r <= 6'h00;
    end else begin
      d1_r   <= {port_a_muxbus_in[2:0], port_b_muxbus_in[2:0]};
      d2_r   <= d1_r;
      d3_r   <= d2_r;
      dflt_r <= (d2_r & d3_r) | (dflt_r & (d2_r ^ d3_r));
    end
  end
  wire       init_n_w = flt_r[23];
  wire       pd_n_w   = flt_r[22];
  wire [7:0] a_bus_w  = {flt_r[9:5], dflt_r[5:3]};
  wire [7:0] b_bus_w  = {flt_r[4:0], dflt_r[2:0]};
  // power-down masks every other input
  wire       act_w    = pd_n_w & init_n_w;
  // ----------------------------------------
  // port decode
  // ----------------------------------------
  function sel_f;
    input sel_n;
    input sel;
    sel_f = ~sel_n & sel;
  endfunction
  wire a_sel_w = sel_f(flt_r[17], flt_r[16]);
  wire b_sel_w = sel_f(flt_r[11], flt_r[10]);
  wire a_rd_w  = act_w & a_sel_w & ~flt_r[19];
  wire b_rd_w  = act_w & b_sel_w & ~flt_r[13];
  wire a_wr_w  = act_w & a_sel_w & ~flt_r[18];
  wire b_wr_w  = act_w & b_sel_w & ~flt_r[12];
  // ----------------------------------------
  // address latches and strobe edges
  // ----------------------------------------
  reg [8:0] a_addr_r, b_addr_r;
  reg       a_ale_q_r, b_ale_q_r, a_wr_q_r, b_wr_q_r;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_addr_r  <= 9'h000;
      b_addr_r  <= 9'h000;
      a_ale_q_r <= 1'b0;
      b_ale_q_r <= 1'b0;
      a_wr_q_r  <= 1'b0;
      b_wr_q_r  <= 1'b0;
    end else begin
      a_ale_q_r <= flt_r[20];
      b_ale_q_r <= flt_r[14];
      a_wr_q_r  <= a_wr_w;
      b_wr_q_r  <= b_wr_w;
      // latch is not gated by select
      if (act_w & a_ale_q_r & ~flt_r[20]) a_addr_r <= {flt_r[21], a_bus_w};
      if (act_w & b_ale_q_r & ~flt_r[14]) b_addr_r <= {flt_r[15], b_bus_w};
    end
  end
  // write commits on the rising edge of the store strobe, when data has settled
  // entering power-down or init is not a strobe end, so nothing is stored then
  wire a_wst_w = a_wr_q_r & ~a_wr_w & act_w;
  wire b_wst_w = b_wr_q_r & ~b_wr_w & act_w;
  // ----------------------------------------
  // shared memory, single clocked arbiter
  // ----------------------------------------
  // both writes land in one cycle; on a same-address clash a's write is dropped, so b's byte is left
  reg [7:0] mem_r [0:`DPM_MEM_BYTES-1];
  wire a_mem_w = a_addr_r < `DPM_MEM_BYTES;
  wire b_mem_w = b_addr_r < `DPM_MEM_BYTES;
  always @(posedge core_clk_in) begin
    if (a_wst_w & a_mem_w & ~(b_wst_w & b_mem_w & (a_addr_r == b_addr_r)))
      mem_r[a_addr_r] <= a_bus_w;
    if (b_wst_w & b_mem_w) mem_r[b_addr_r] <= b_bus_w;
  end
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port_a_muxbus_out    <= 8'h00;
      port_b_muxbus_out    <= 8'h00;
      port_a_muxbus_oe_out <= 1'b0;
      port_b_muxbus_oe_out <= 1'b0;
    end else begin
      // registered read: a byte is either fully old or fully new
      port_a_muxbus_out    <= a_mem_w ? mem_r[a_addr_r] : 8'h00;
      port_b_muxbus_out    <= b_mem_w ? mem_r[b_addr_r] : 8'h00;
      port_a_muxbus_oe_out <= a_rd_w;
      port_b_muxbus_oe_out <= b_rd_w;
    end
  end
  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  function [1:0] irq_f;
    input       cur;
    input [7:0] d;
    begin
      case (d[`DPM_IRQ_CMD_HI:`DPM_IRQ_CMD_LO])
        `DPM_IRQ_CMD_SET: irq_f = 2'h1;
        `DPM_IRQ_CMD_CLR: irq_f = 2'h0;
        default:          irq_f = {1'b0, cur};
      endcase
    end
  endfunction
  reg [2:0] irq_r;
  reg [2:0] irq_nxt;
  integer k;
  always @* begin
    irq_nxt = irq_r;
    for (k = 0; k < 3; k = k + 1) begin
      if (a_wst_w && a_addr_r == `DPM_IRQ_BASE + k) irq_nxt[k] = irq_f(irq_nxt[k], a_bus_w) != 2'h0;
      if (b_wst_w && b_addr_r == `DPM_IRQ_BASE + k) irq_nxt[k] = irq_f(irq_nxt[k], b_bus_w) != 2'h0;
    end
  end
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) irq_r <= 3'h0;
    else if (!act_w) irq_r <= 3'h0;
    else irq_r <= irq_nxt;
  end
  // ----------------------------------------
  // clock output and oscillator alive
  // ----------------------------------------
  // the core clock stands in for the oscillator; power-down gates it off
  reg [7:0] div_r;
  reg       run_r;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r <= 8'h00;
      clock_out <= 1'b0;
      run_r <= 1'b0;
    end else if (!pd_n_w) begin
      div_r <= 8'h00;
      clock_out <= 1'b0;
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
      if (div_r == CLK_DIV[7:0] - 8'h01) begin
        div_r <= 8'h00;
        clock_out <= ~clock_out;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_alive_oe_out   <= 1'b1;
      timer_a_out_oe_out <= 1'b1;
      timer_b_out_oe_out <= 1'b1;
      timer_c_out_oe_out <= 1'b1;
      irq_out_a_oe_out   <= 1'b1;
      irq_out_b_oe_out   <= 1'b1;
      irq_out_c_oe_out   <= 1'b1;
    end else begin
      osc_alive_oe_out   <= ~run_r;
      timer_a_out_oe_out <= ~act_w;
      timer_b_out_oe_out <= ~act_w;
      timer_c_out_oe_out <= ~act_w;
      irq_out_a_oe_out   <= ~irq_nxt[0] | ~act_w;
      irq_out_b_oe_out   <= ~irq_nxt[1] | ~act_w;
      irq_out_c_oe_out   <= ~irq_nxt[2] | ~act_w;
    end
  end
endmodule // dpm_top

// file: design/dpm_map.vh
`ifndef DPM_MAP_VH
`define DPM_MAP_VH
// ----------------------------------------
// memory geometry
// ----------------------------------------
`define DPM_MEM_BYTES      504
`define DPM_ADDR_W         9
// ----------------------------------------
// interrupt output control
// ----------------------------------------
`define DPM_IRQ_BASE       9'h1fd
`define DPM_IRQ_CMD_HI     3
`define DPM_IRQ_CMD_LO     2
`define DPM_IRQ_CMD_KEEP   2'h0
`define DPM_IRQ_CMD_SET    2'h1
`define DPM_IRQ_CMD_CLR    2'h2
// ----------------------------------------
// clock output and oscillator watchdog
// ----------------------------------------
`define DPM_CLK_DIV        2
`define DPM_INIT_MIN_CYC   7
// ----------------------------------------
// synchroniser reset value
// ----------------------------------------
// idle pin levels: controls, strobes and active-low selects high; latches, active-high selects, address high and bus low
`define DPM_SYNC_RST       24'hce3800
`endif

// file: test/dpm_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks
// ----------------------------------------
module dpm_checker #(
  parameter CLK_DIV = 2
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic chip_init_n_in,
  input wire logic power_down_n_in,
  input wire logic port_a_read_strobe_n_in,
  input wire logic port_a_select_n_in,
  input wire logic port_a_select_in,
  input wire logic port_a_muxbus_oe_out,
  input wire logic port_b_muxbus_oe_out,
  input wire logic clock_out,
  input wire logic osc_alive_oe_out,
  input wire logic timer_a_out_oe_out,
  input wire logic irq_out_a_oe_out
);
  localparam int HALF = CLK_DIV;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // pins pass a synchroniser and filter, so the cause sits five edges back and must still hold three back
  a_read_has_cause: assert property ($rose(port_a_muxbus_oe_out) |->
    $past(!port_a_read_strobe_n_in && !port_a_select_n_in && port_a_select_in, 3))
    else $error("bus driven without selected read");
  a_pd_clock_low: assert property (!power_down_n_in [*8] |-> !clock_out)
    else $error("clock out runs in power down");
  a_pd_osc_flag: assert property (!power_down_n_in [*8] |-> osc_alive_oe_out)
    else $error("oscillator flag released in power down");
  a_pd_bus_off: assert property (!power_down_n_in [*8] |->
    !port_a_muxbus_oe_out && !port_b_muxbus_oe_out) else $error("bus driven in power down");
  a_init_timer_low: assert property (!chip_init_n_in [*8] |-> timer_a_out_oe_out)
    else $error("timer output released during init");
  a_init_irq_clear: assert property (!chip_init_n_in [*8] |-> irq_out_a_oe_out)
    else $error("irq level not cleared by init");
  a_clock_runs: assert property (power_down_n_in [*8] |-> ##[1:HALF] $changed(clock_out))
    else $error("clock out stalled");
  a_osc_alive_up: assert property (power_down_n_in [*8] |-> !osc_alive_oe_out)
    else $error("oscillator flag low while running");
endmodule // dpm_checker

bind dpm_top dpm_checker #(.CLK_DIV(CLK_DIV)) u_chk (.*);

// file: test/dpm_mcu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// bus master on one port
// ----------------------------------------
module dpm_mcu_model (
  // clock and device side
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_d_in,
  input  wire logic       dev_oe_in,
  // port pins
  output wire logic [7:0] bus_out,
  output logic            addr_hi_out = 1'b0,
  output logic            latch_out = 1'b0,
  output logic            rd_n_out = 1'b1,
  output logic            wr_n_out = 1'b1,
  output logic            sel_n_out = 1'b1,
  output logic            sel_out = 1'b0
);
  logic [7:0] d_r = 8'h00;
  logic       drv_r = 1'b0;
  // a released bus shows the inverse of the last byte so stale data never looks valid
  assign bus_out = dev_oe_in ? dev_d_in : (drv_r ? d_r : ~d_r);
  task automatic xfer(input logic w, input logic [1:0] cs, input logic [8:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic seen);
    @(posedge clk_in);
    drv_r <= 1'b1;
    // a wrong byte first, so a capture on the rising latch edge is caught
    d_r <= ~a[7:0];
    addr_hi_out <= a[8];
    latch_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    d_r <= a[7:0];
    repeat (2) @(posedge clk_in);
    latch_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    {sel_n_out, sel_out} <= cs;
    d_r <= d;
    drv_r <= w;
    rd_n_out <= w;
    wr_n_out <= !w;
    seen = 1'b0;
    for (int n = 0; n < 12 && !seen; n++) begin
      @(negedge clk_in);
      seen = dev_oe_in;
      q = dev_d_in;
    end
    @(posedge clk_in);
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    // data held past the filtered strobe edge, where the write is taken
    repeat (6) @(posedge clk_in);
    {sel_n_out, sel_out} <= 2'b10;
    drv_r <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // dpm_mcu_model

// file: test/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench;
  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic       core_clk_in = 0, arst_n_in = 0, chip_init_n_in = 1, power_down_n_in = 1;
  int         num_errors = 0, total_checks = 0, n;
  logic [7:0] q;
  logic       s;
  wire  [7:0] port_a_muxbus_in, port_a_muxbus_out, port_b_muxbus_in, port_b_muxbus_out;
  wire        port_a_muxbus_oe_out, port_b_muxbus_oe_out, clock_out, osc_alive_oe_out;
  wire        port_a_addr_hi_in, port_a_addr_latch_in, port_a_read_strobe_n_in;
  wire        port_a_store_strobe_n_in, port_a_select_n_in, port_a_select_in;
  wire        port_b_addr_hi_in, port_b_addr_latch_in, port_b_read_strobe_n_in;
  wire        port_b_store_strobe_n_in, port_b_select_n_in, port_b_select_in;
  wire        timer_a_out_oe_out, timer_b_out_oe_out, timer_c_out_oe_out;
  wire        irq_out_a_oe_out, irq_out_b_oe_out, irq_out_c_oe_out;
  always #12.5 core_clk_in = ~core_clk_in;
  dpm_top #(.CLK_DIV(2)) u_dut (.*);
  dpm_mcu_model u_pa (.clk_in(core_clk_in), .dev_d_in(port_a_muxbus_out),
    .dev_oe_in(port_a_muxbus_oe_out), .bus_out(port_a_muxbus_in), .addr_hi_out(port_a_addr_hi_in),
    .latch_out(port_a_addr_latch_in), .rd_n_out(port_a_read_strobe_n_in),
    .wr_n_out(port_a_store_strobe_n_in), .sel_n_out(port_a_select_n_in), .sel_out(port_a_select_in));
  dpm_mcu_model u_pb (.clk_in(core_clk_in), .dev_d_in(port_b_muxbus_out),
    .dev_oe_in(port_b_muxbus_oe_out), .bus_out(port_b_muxbus_in), .addr_hi_out(port_b_addr_hi_in),
    .latch_out(port_b_addr_latch_in), .rd_n_out(port_b_read_strobe_n_in),
    .wr_n_out(port_b_store_strobe_n_in), .sel_n_out(port_b_select_n_in), .sel_out(port_b_select_in));
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic acc(input bit b, input logic w, input logic [1:0] cs, input logic [8:0] a,
                     input logic [7:0] d);
    if (b) u_pb.xfer(w, cs, a, d, q, s);
    else u_pa.xfer(w, cs, a, d, q, s);
  endtask
  task automatic toggles(input int c);
    logic p;
    n = 0;
    p = clock_out;
    repeat (c) begin
      @(negedge core_clk_in);
      n += (clock_out !== p);
      p = clock_out;
    end
    @(posedge core_clk_in);
  endtask
  task automatic t_mem;
    acc(0, 1, 2'b01, 9'h000, 8'ha5);
    acc(0, 1, 2'b01, 9'h1f7, 8'h5a);
    acc(1, 1, 2'b01, 9'h100, 8'hc3);
    acc(1, 0, 2'b01, 9'h000, 8'h00);
    `CHK({s, q}, 9'h1a5)
    acc(1, 0, 2'b01, 9'h1f7, 8'h00);
    `CHK({s, q}, 9'h15a)
    acc(0, 0, 2'b01, 9'h100, 8'h00);
    `CHK({s, q}, 9'h1c3)
    acc(0, 0, 2'b01, 9'h1f8, 8'hff);
    `CHK({s, q}, 9'h100)
  endtask
  task automatic t_select;
    for (int i = 0; i < 4; i += 3) begin
      acc(0, 1, i[1:0], 9'h000, 8'h11);
      acc(1, 0, i[1:0], 9'h000, 8'h00);
      `CHK(s, 1'b0)
    end
    acc(1, 0, 2'b01, 9'h000, 8'h00);
    `CHK({s, q}, 9'h1a5)
  endtask
  task automatic t_collide;
    logic [7:0] qw;
    logic       sw;
    fork
      u_pa.xfer(1, 2'b01, 9'h040, 8'h12, qw, sw);
      u_pb.xfer(1, 2'b01, 9'h040, 8'h34, q, s);
    join
    acc(0, 0, 2'b01, 9'h040, 8'h00);
    `CHK({s, q}, 9'h134)
    acc(0, 1, 2'b01, 9'h080, 8'h66);
    fork
      u_pa.xfer(1, 2'b01, 9'h080, 8'h99, qw, sw);
      u_pb.xfer(0, 2'b01, 9'h080, 8'h00, q, s);
    join
    `CHK({s, q == 8'h66 || q == 8'h99}, 2'b11)
    acc(1, 0, 2'b01, 9'h080, 8'h00);
    `CHK({s, q}, 9'h199)
  endtask
  task automatic t_irq;
    acc(0, 1, 2'b01, 9'h1fd, 8'h04);
    `CHK(irq_out_a_oe_out, 1'b0)
    acc(1, 1, 2'b01, 9'h1fd, 8'h00);
    `CHK(irq_out_a_oe_out, 1'b0)
    acc(1, 1, 2'b01, 9'h1fd, 8'h08);
    acc(1, 1, 2'b01, 9'h1fe, 8'h05);
    acc(0, 1, 2'b01, 9'h1ff, 8'h06);
    `CHK({irq_out_a_oe_out, irq_out_b_oe_out, irq_out_c_oe_out}, 3'b100)
    chip_init_n_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    `CHK({timer_a_out_oe_out, timer_b_out_oe_out, timer_c_out_oe_out, irq_out_b_oe_out}, 4'hf)
    chip_init_n_in <= 1'b1;
    toggles(8);
    `CHK({timer_a_out_oe_out, timer_b_out_oe_out, timer_c_out_oe_out}, 3'b000)
  endtask
  task automatic t_pd;
    acc(0, 1, 2'b01, 9'h010, 8'h3c);
    toggles(16);
    `CHK(n, 8)
    `CHK(osc_alive_oe_out, 1'b0)
    power_down_n_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    toggles(16);
    `CHK(n, 0)
    `CHK(osc_alive_oe_out, 1'b1)
    acc(0, 1, 2'b01, 9'h010, 8'hc3);
    power_down_n_in <= 1'b1;
    t_irq;
    acc(1, 0, 2'b01, 9'h010, 8'h00);
    `CHK({s, q}, 9'h13c)
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    t_mem;
    t_select;
    t_collide;
    t_irq;
    t_pd;
    end_of_test;
  end
endmodule // testbench
